// ---- design/csrm_bank.sv ----
// control/status register bank with the first status monitor multiplexer
//
// Notes on behaviour
// - routing register bit 7 set powers down the cleanup loop output driver
// - routing bits 6:4 pick divider for channels 9,8,7; 0 first, 1 second
// - routing bits 3:0 set route vcxo clock to channels 3..0 divider
// - lock status bits 7:2 report presence of six clocks, 1 present
// - lock status bit 1 synthesis loop lock, bit 0 cleanup loop lock
// - holdover status bit 3 is 1 while holdover is active
// - holdover status bit 2 shows auto-selected reference, 1 is reference b
// - holdover status bit 0 shows calibration running; bits 7:4 and 1 reserved
// - monitor select field 5:0 picks monitor output; zero drives ground
// - codes 1..3: both locked, cleanup locked, synthesis locked
// - codes 4..6: no references, no references with lock, b auto-selected
// - code 13 reserved; 14 both references ok; 15 all but test ok
// - codes 16..19: divide-by-2 of feedback, pfd down, reference, pfd up
module csrm_bank
    import csrm_pkg::*;
#(
    parameter int ADDR_W      = 10,
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // register port from the serial control port decoder
    input  wire logic [ADDR_W-1:0]        reg_addr,
    input  wire logic                     reg_wr_en,
    input  wire logic [7:0]               reg_wr_data,
    input  wire logic                     reg_rd_en,
    output logic      [7:0]               reg_rd_data,
    output logic                          reg_rd_valid,
    // status from the analog loops, asynchronous
    input  wire logic                     cleanup_locked,
    input  wire logic                     synth_locked,
    input  wire logic                     reference_input_a_ok,
    input  wire logic                     reference_input_b_ok,
    input  wire logic                     test_ref_ok,
    input  wire logic                     vcxo_ok,
    input  wire logic                     synth_fb_ok,
    input  wire logic                     synth_ref_ok,
    input  wire logic                     cleanup_fb_ok,
    input  wire logic                     holdover_active,
    input  wire logic                     auto_sel_ref_b,
    input  wire logic                     vco_cal_busy,
    // fast loop signals, asynchronous
    input  wire logic                     cleanup_fb_clk,
    input  wire logic                     pfd_down,
    input  wire logic                     cleanup_ref_clk,
    input  wire logic                     pfd_up,
    // control outputs
    output logic                          cleanup_drv_pdown,
    output logic [CSRM_DIVSEL_W-1:0]      channel_divider_source_sel,
    output logic [CSRM_VCXO_W-1:0]        vcxo_route,
    output logic [CSRM_MSEL_W-1:0]        monitor_zero_sel,
    output logic                          monitor_zero_out
);

    localparam int NSYNC = CSRM_ST_W + CSRM_FS_W;

    // offsets are ten bits wide; a narrower address would alias them
    if (ADDR_W < 10) begin : g_bad_addr_w
        $error("csrm_bank: ADDR_W must be at least 10");
    end
    // one flop alone would pass a metastable level to the readback
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("csrm_bank: SYNC_STAGES must be at least 2");
    end

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    wire logic [NSYNC-1:0] raw_in;
    logic      [NSYNC-1:0] sync_q [SYNC_STAGES];
    wire logic [NSYNC-1:0] sync_out;

    assign raw_in = {pfd_up,
                     cleanup_ref_clk,
                     pfd_down,
                     cleanup_fb_clk,
                     vco_cal_busy,
                     auto_sel_ref_b,
                     holdover_active,
                     cleanup_fb_ok,
                     synth_ref_ok,
                     synth_fb_ok,
                     vcxo_ok,
                     test_ref_ok,
                     reference_input_b_ok,
                     reference_input_a_ok,
                     synth_locked,
                     cleanup_locked};

    genvar gs;
    generate
        for (gs = 0; gs < SYNC_STAGES; gs++) begin : g_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    sync_q[gs] <= '0;
                end else if (gs == 0) begin
                    sync_q[gs] <= raw_in;
                end else begin
                    sync_q[gs] <= sync_q[(gs == 0) ? 0 : gs-1];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q[SYNC_STAGES-1];

    wire logic [CSRM_ST_W-1:0] st;
    wire logic [CSRM_FS_W-1:0] fs;
    assign st = sync_out[CSRM_ST_W-1:0];
    assign fs = sync_out[NSYNC-1:CSRM_ST_W];

    // ---------------------------------------------------------------
    // divide-by-2 of the fast signals; a rising edge toggles a flop.
    // limitation: edges closer than two clk periods are not resolved,
    // so this is a coarse activity indicator, not a true frequency copy
    // ---------------------------------------------------------------
    logic      [CSRM_FS_W-1:0] fs_prev_q;
    logic      [CSRM_FS_W-1:0] half_q;
    wire logic [CSRM_FS_W-1:0] fs_rise;

    assign fs_rise = fs & ~fs_prev_q;

    genvar gf;
    generate
        for (gf = 0; gf < CSRM_FS_W; gf++) begin : g_half
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    fs_prev_q[gf] <= 1'b0;
                    half_q[gf]    <= 1'b0;
                end else begin
                    fs_prev_q[gf] <= fs[gf];
                    if (fs_rise[gf]) begin
                        half_q[gf] <= ~half_q[gf];
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    wire logic hit_route;
    wire logic hit_lock;
    wire logic hit_hold;
    wire logic hit_mon0;

    assign hit_route = (reg_addr == ADDR_W'(CSRM_ROUTE_OFS));
    assign hit_lock  = (reg_addr == ADDR_W'(CSRM_LOCK_OFS));
    assign hit_hold  = (reg_addr == ADDR_W'(CSRM_HOLD_OFS));
    assign hit_mon0  = (reg_addr == ADDR_W'(CSRM_MON0_OFS));

    // ---------------------------------------------------------------
    // writable registers; status registers take no write at all
    // ---------------------------------------------------------------
    logic [7:0]             route_q;
    logic [CSRM_MSEL_W-1:0] msel_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            route_q <= CSRM_ROUTE_RST;
        end else if (reg_wr_en && hit_route) begin
            route_q <= reg_wr_data;
        end
    end

    // reserved bits 7:6 are dropped on write and read back as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            msel_q <= CSRM_MON0_RST;
        end else if (reg_wr_en && hit_mon0) begin
            msel_q <= reg_wr_data[CSRM_MSEL_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // live status images
    // ---------------------------------------------------------------
    wire logic [7:0] lock_img;
    wire logic [7:0] hold_img;

    assign lock_img = {st[CSRM_ST_SY_REF],
                       st[CSRM_ST_SY_FB],
                       st[CSRM_ST_VCXO],
                       st[CSRM_ST_REFT],
                       st[CSRM_ST_REFERENCE_INPUT_B],
                       st[CSRM_ST_REFERENCE_INPUT_A],
                       st[CSRM_ST_LOCK_SY],
                       st[CSRM_ST_LOCK_CL]};

    assign hold_img = {4'h0,
                       st[CSRM_ST_HOLD],
                       st[CSRM_ST_AUTO_B],
                       1'b0,
                       st[CSRM_ST_CAL]};

    wire logic [7:0] rd_mux;
    assign rd_mux = hit_route ? route_q :
                    hit_lock  ? lock_img :
                    hit_hold  ? hold_img :
                    hit_mon0  ? {2'h0, msel_q} :
                    8'h00;

    // read answers one cycle later, sampled at the request edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rd_data  <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data <= rd_mux;
            end
        end
    end

    // ---------------------------------------------------------------
    // control outputs straight from flops
    // ---------------------------------------------------------------
    wire logic                     pdown_fld;
    wire logic [CSRM_DIVSEL_W-1:0] divsel_fld;
    wire logic [CSRM_VCXO_W-1:0]   vcxo_fld;

    assign pdown_fld  = route_q[CSRM_PDOWN_BIT];
    assign divsel_fld = route_q[CSRM_DIVSEL_LSB +: CSRM_DIVSEL_W];
    assign vcxo_fld   = route_q[CSRM_VCXO_LSB +: CSRM_VCXO_W];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cleanup_drv_pdown          <= CSRM_ROUTE_RST[CSRM_PDOWN_BIT];
            channel_divider_source_sel <= CSRM_ROUTE_RST[CSRM_DIVSEL_LSB +: CSRM_DIVSEL_W];
            vcxo_route                 <= CSRM_ROUTE_RST[CSRM_VCXO_LSB +: CSRM_VCXO_W];
            monitor_zero_sel           <= CSRM_MON0_RST;
        end else begin
            cleanup_drv_pdown          <= pdown_fld;
            channel_divider_source_sel <= divsel_fld;
            vcxo_route                 <= vcxo_fld;
            monitor_zero_sel           <= msel_q;
        end
    end

    // ---------------------------------------------------------------
    // status monitor 0 multiplexer
    // ---------------------------------------------------------------
    wire logic both_lk;
    wire logic no_ref;
    wire logic no_ref_lk;
    wire logic refs_ok;
    wire logic all_ok;

    assign both_lk   = st[CSRM_ST_LOCK_CL] && st[CSRM_ST_LOCK_SY];
    assign no_ref    = !st[CSRM_ST_REFERENCE_INPUT_A] && !st[CSRM_ST_REFERENCE_INPUT_B];
    assign no_ref_lk = no_ref && st[CSRM_ST_LOCK_SY];
    assign refs_ok   = st[CSRM_ST_REFERENCE_INPUT_A] && st[CSRM_ST_REFERENCE_INPUT_B];
    // test reference left out so a bench source does not mask the rest
    assign all_ok    = refs_ok
                    && st[CSRM_ST_VCXO]
                    && st[CSRM_ST_CL_FB]
                    && st[CSRM_ST_SY_REF]
                    && st[CSRM_ST_SY_FB];

    logic mon_d;
    always_comb begin
        case (msel_q)
            CSRM_M_GND:      mon_d = 1'b0;
            CSRM_M_BOTH_LK:  mon_d = both_lk;
            CSRM_M_CL_LK:    mon_d = st[CSRM_ST_LOCK_CL];
            CSRM_M_SY_LK:    mon_d = st[CSRM_ST_LOCK_SY];
            CSRM_M_NOREF:    mon_d = no_ref;
            CSRM_M_NOREF_LK: mon_d = no_ref_lk;
            CSRM_M_AUTO_B:   mon_d = st[CSRM_ST_AUTO_B];
            CSRM_M_REFERENCE_INPUT_A_OK:  mon_d = st[CSRM_ST_REFERENCE_INPUT_A];
            CSRM_M_REFERENCE_INPUT_B_OK:  mon_d = st[CSRM_ST_REFERENCE_INPUT_B];
            CSRM_M_REFT_OK:  mon_d = st[CSRM_ST_REFT];
            CSRM_M_VCXO_OK:  mon_d = st[CSRM_ST_VCXO];
            CSRM_M_CLFB_OK:  mon_d = st[CSRM_ST_CL_FB];
            CSRM_M_SYREF_OK: mon_d = st[CSRM_ST_SY_REF];
            CSRM_M_RSVD:     mon_d = 1'b0;
            CSRM_M_REFS_OK:  mon_d = refs_ok;
            CSRM_M_ALL_OK:   mon_d = all_ok;
            CSRM_M_CLFB_D2:  mon_d = half_q[CSRM_FS_CL_FB];
            CSRM_M_PFDDN_D2: mon_d = half_q[CSRM_FS_PFD_DN];
            CSRM_M_CLREF_D2: mon_d = half_q[CSRM_FS_CL_REF];
            CSRM_M_PFDUP_D2: mon_d = half_q[CSRM_FS_PFD_UP];
            // 20..23 ground; reserved codes above also ground, a safe answer
            default:         mon_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            monitor_zero_out <= 1'b0;
        end else begin
            monitor_zero_out <= mon_d;
        end
    end

endmodule

// ---- shared/csrm_pkg.sv ----
// constants for the clock status register bank and monitor multiplexer
package csrm_pkg;
    // register offsets
    localparam logic [9:0] CSRM_ROUTE_OFS   = 10'h1bb;
    localparam logic [9:0] CSRM_LOCK_OFS    = 10'h22c;
    localparam logic [9:0] CSRM_HOLD_OFS    = 10'h22d;
    localparam logic [9:0] CSRM_MON0_OFS    = 10'h230;
    // reset values
    localparam logic [7:0] CSRM_ROUTE_RST   = 8'h00;
    localparam logic [5:0] CSRM_MON0_RST    = 6'h00;
    // routing register fields
    localparam int         CSRM_PDOWN_BIT   = 7;
    localparam int         CSRM_DIVSEL_LSB  = 4;
    localparam int         CSRM_DIVSEL_W    = 3;
    localparam int         CSRM_VCXO_LSB    = 0;
    localparam int         CSRM_VCXO_W      = 4;
    // monitor select field
    localparam int         CSRM_MSEL_W      = 6;
    // status vector bit positions (synchronised inputs)
    localparam int         CSRM_ST_LOCK_CL  = 0;
    localparam int         CSRM_ST_LOCK_SY  = 1;
    localparam int         CSRM_ST_REFERENCE_INPUT_A     = 2;
    localparam int         CSRM_ST_REFERENCE_INPUT_B     = 3;
    localparam int         CSRM_ST_REFT     = 4;
    localparam int         CSRM_ST_VCXO     = 5;
    localparam int         CSRM_ST_SY_FB    = 6;
    localparam int         CSRM_ST_SY_REF   = 7;
    localparam int         CSRM_ST_CL_FB    = 8;
    localparam int         CSRM_ST_HOLD     = 9;
    localparam int         CSRM_ST_AUTO_B   = 10;
    localparam int         CSRM_ST_CAL      = 11;
    localparam int         CSRM_ST_W        = 12;
    // fast signals shown divided by two
    localparam int         CSRM_FS_CL_FB    = 0;
    localparam int         CSRM_FS_PFD_DN   = 1;
    localparam int         CSRM_FS_CL_REF   = 2;
    localparam int         CSRM_FS_PFD_UP   = 3;
    localparam int         CSRM_FS_W        = 4;
    // monitor select codes
    localparam logic [5:0] CSRM_M_GND       = 6'h00;
    localparam logic [5:0] CSRM_M_BOTH_LK   = 6'h01;
    localparam logic [5:0] CSRM_M_CL_LK     = 6'h02;
    localparam logic [5:0] CSRM_M_SY_LK     = 6'h03;
    localparam logic [5:0] CSRM_M_NOREF     = 6'h04;
    localparam logic [5:0] CSRM_M_NOREF_LK  = 6'h05;
    localparam logic [5:0] CSRM_M_AUTO_B    = 6'h06;
    localparam logic [5:0] CSRM_M_REFERENCE_INPUT_A_OK   = 6'h07;
    localparam logic [5:0] CSRM_M_REFERENCE_INPUT_B_OK   = 6'h08;
    localparam logic [5:0] CSRM_M_REFT_OK   = 6'h09;
    localparam logic [5:0] CSRM_M_VCXO_OK   = 6'h0a;
    localparam logic [5:0] CSRM_M_CLFB_OK   = 6'h0b;
    localparam logic [5:0] CSRM_M_SYREF_OK  = 6'h0c;
    localparam logic [5:0] CSRM_M_RSVD      = 6'h0d;
    localparam logic [5:0] CSRM_M_REFS_OK   = 6'h0e;
    localparam logic [5:0] CSRM_M_ALL_OK    = 6'h0f;
    localparam logic [5:0] CSRM_M_CLFB_D2   = 6'h10;
    localparam logic [5:0] CSRM_M_PFDDN_D2  = 6'h11;
    localparam logic [5:0] CSRM_M_CLREF_D2  = 6'h12;
    localparam logic [5:0] CSRM_M_PFDUP_D2  = 6'h13;
endpackage

// ---- test/csrm_bank_assertions.sv ----
// concurrent checks on the register port and monitor output of the status bank
module csrm_bank_assertions
    import csrm_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr_en,
    input wire logic [7:0]        reg_wr_data,
    input wire logic              reg_rd_en,
    input wire logic [7:0]        reg_rd_data,
    input wire logic              reg_rd_valid,
    // loop status
    input wire logic              cleanup_locked,
    input wire logic              synth_locked,
    input wire logic              reference_input_a_ok,
    input wire logic              reference_input_b_ok,
    // controls and monitor
    input wire logic              cleanup_drv_pdown,
    input wire logic [2:0]        channel_divider_source_sel,
    input wire logic [3:0]        vcxo_route,
    input wire logic [5:0]        monitor_zero_sel,
    input wire logic              monitor_zero_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire       wr_route = reg_wr_en && reg_addr == CSRM_ROUTE_OFS;
    wire       wr_mon   = reg_wr_en && reg_addr == CSRM_MON0_OFS;
    wire       rd_hold  = reg_rd_en && reg_addr == CSRM_HOLD_OFS;
    wire [7:0] route_v  = {cleanup_drv_pdown, channel_divider_source_sel, vcxo_route};
    // codes that must drive ground, reserved 13 included
    wire       gnd_code = monitor_zero_sel inside {6'h00, 6'h0d} || monitor_zero_sel > 6'h13;
    // select and monitor leave the same flop stage, so they line up cycle for cycle
    wire       cl_lk_on = monitor_zero_sel == 6'h02 && cleanup_locked;
    wire       sy_unlk  = monitor_zero_sel == 6'h01 && !synth_locked;
    wire       refs_off = monitor_zero_sel == 6'h04 && !reference_input_a_ok
                          && !reference_input_b_ok;

    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe got no answer");
    a_no_stray_valid: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("answer without a read");
    a_route_follow: assert property (
            wr_route |-> ##2 route_v == $past(reg_wr_data, 2))
        else $error("routing outputs differ from written byte");
    a_msel_follow: assert property (
            wr_mon |-> ##2 {2'b00, monitor_zero_sel} == ($past(reg_wr_data, 2) & 8'h3f))
        else $error("monitor select differs from written field");
    a_hold_rsvd_zero: assert property (rd_hold |=> (reg_rd_data & 8'hf2) == 8'h00)
        else $error("reserved holdover bits not zero");
    a_mon_gnd: assert property (
            gnd_code && $past(gnd_code) |-> !monitor_zero_out)
        else $error("ground code drives the monitor high");
    a_mon_cl_lock: assert property (cl_lk_on[*4] |-> monitor_zero_out)
        else $error("cleanup lock not shown on monitor");
    a_mon_unlock: assert property (sy_unlk[*4] |-> !monitor_zero_out)
        else $error("both locked shown while synthesis loop unlocked");
    a_mon_no_refs: assert property (refs_off[*4] |-> monitor_zero_out)
        else $error("missing references not shown on monitor");

    c_read: cover property (reg_rd_en ##1 reg_rd_valid);
    c_route_write: cover property (wr_route ##2 cleanup_drv_pdown);
    c_mon_high: cover property (!gnd_code ##1 monitor_zero_out);
endmodule

// ---- test/csrm_bank_tb.sv ----
// self-checking bench for the clock status register bank
module csrm_bank_tb
    import csrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0;
    logic                 nrst = 1'b0;
    logic [9:0]           reg_addr = 10'h000;
    logic [7:0]           reg_wr_data = 8'h00;
    logic                 reg_wr_en = 1'b0;
    logic                 reg_rd_en = 1'b0;
    logic [7:0]           reg_rd_data, rdv, rov;
    logic                 reg_rd_valid, cleanup_drv_pdown, monitor_zero_out, o0, e;
    logic [2:0]           channel_divider_source_sel;
    logic [3:0]           vcxo_route;
    logic [5:0]           monitor_zero_sel;
    logic [CSRM_ST_W-1:0] st = 12'h000;
    logic [CSRM_FS_W-1:0] fs = 4'h0;
    wire logic            cleanup_locked, synth_locked, reference_input_a_ok, reference_input_b_ok;
    wire logic            test_ref_ok, vcxo_ok, synth_fb_ok, synth_ref_ok, cleanup_fb_ok;
    wire logic            holdover_active, auto_sel_ref_b, vco_cal_busy;
    wire logic            cleanup_fb_clk, pfd_down, cleanup_ref_clk, pfd_up;
    int                   miscompares = 0;
    int                   cmp_count = 0;
    logic [11:0]          pats [4] = '{12'h000, 12'hfff, 12'h2a9, 12'hd56};

    always #2 clk = ~clk;
    csrm_bank dut_u (.*);
    csrm_loop_model loop_u (.*);

    function automatic logic [7:0] lock_img(logic [11:0] s);
        return {s[CSRM_ST_SY_REF], s[CSRM_ST_SY_FB], s[CSRM_ST_VCXO], s[CSRM_ST_REFT],
                s[CSRM_ST_REFERENCE_INPUT_B], s[CSRM_ST_REFERENCE_INPUT_A], s[CSRM_ST_LOCK_SY], s[CSRM_ST_LOCK_CL]};
    endfunction
    function automatic logic [7:0] hold_img(logic [11:0] s);
        return {4'h0, s[CSRM_ST_HOLD], s[CSRM_ST_AUTO_B], 1'b0, s[CSRM_ST_CAL]};
    endfunction
    function automatic logic mon_exp(logic [5:0] c, logic [11:0] s);
        case (c)
            6'h01: return s[CSRM_ST_LOCK_CL] & s[CSRM_ST_LOCK_SY];
            6'h02: return s[CSRM_ST_LOCK_CL];
            6'h03: return s[CSRM_ST_LOCK_SY];
            6'h04: return !s[CSRM_ST_REFERENCE_INPUT_A] && !s[CSRM_ST_REFERENCE_INPUT_B];
            6'h05: return !s[CSRM_ST_REFERENCE_INPUT_A] && !s[CSRM_ST_REFERENCE_INPUT_B] && s[CSRM_ST_LOCK_SY];
            6'h06: return s[CSRM_ST_AUTO_B];
            6'h07: return s[CSRM_ST_REFERENCE_INPUT_A];
            6'h08: return s[CSRM_ST_REFERENCE_INPUT_B];
            6'h09: return s[CSRM_ST_REFT];
            6'h0a: return s[CSRM_ST_VCXO];
            6'h0b: return s[CSRM_ST_CL_FB];
            6'h0c: return s[CSRM_ST_SY_REF];
            6'h0e: return s[CSRM_ST_REFERENCE_INPUT_A] & s[CSRM_ST_REFERENCE_INPUT_B];
            6'h0f: return &{s[CSRM_ST_REFERENCE_INPUT_A], s[CSRM_ST_REFERENCE_INPUT_B], s[CSRM_ST_VCXO],
                            s[CSRM_ST_CL_FB], s[CSRM_ST_SY_REF], s[CSRM_ST_SY_FB]};
            default: return 1'b0;
        endcase
    endfunction

    task automatic chk(string n, logic [7:0] ex, logic [7:0] seen);
        cmp_count++;
        if (seen !== ex) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, ex, seen);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rc(string n, logic [9:0] a, logic [7:0] ex);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        // the answer stands for one cycle only, look while it does
        #1;
        chk("read valid", 8'h01, 8'(reg_rd_valid));
        chk(n, ex, reg_rd_data);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rc("route reset", CSRM_ROUTE_OFS, CSRM_ROUTE_RST);
        rc("monitor reset", CSRM_MON0_OFS, {2'b00, CSRM_MON0_RST});
        rc("unmapped", 10'h3ff, 8'h00);
        $display("test reset values done");
        foreach (pats[i]) begin
            rdv = i[0] ? 8'h7a : 8'h85;
            wr(CSRM_ROUTE_OFS, rdv);
            repeat (2) @(posedge clk);
            #1;
            rov = {cleanup_drv_pdown, channel_divider_source_sel, vcxo_route};
            chk("route outputs", rdv, rov);
            rc("route read", CSRM_ROUTE_OFS, rdv);
        end
        wr(CSRM_MON0_OFS, 8'hd7);
        rc("monitor field", CSRM_MON0_OFS, 8'h17);
        $display("test control registers done");
        foreach (pats[p]) begin
            @(posedge clk);
            st <= pats[p];
            // writes to the read-only images must leave them live
            wr(CSRM_LOCK_OFS, 8'hff);
            wr(CSRM_HOLD_OFS, 8'hff);
            rc("lock status", CSRM_LOCK_OFS, lock_img(pats[p]));
            rc("hold status", CSRM_HOLD_OFS, hold_img(pats[p]));
            // codes above 23 are never written, the host must keep off them
            for (int c = 0; c < 24; c++) begin
                if (c inside {[16:19]}) continue;
                wr(CSRM_MON0_OFS, 8'(c));
                repeat (3) @(posedge clk);
                #1;
                e = mon_exp(6'(c), pats[p]);
                rov = 8'(monitor_zero_out);
                chk("monitor", 8'(e), rov);
            end
        end
        $display("test status and monitor done");
        for (int c = 16; c < 20; c++) begin
            wr(CSRM_MON0_OFS, 8'(c));
            repeat (3) @(posedge clk);
            #1;
            o0 = monitor_zero_out;
            @(posedge clk);
            fs[c-16] <= 1'b1;
            repeat (3) @(posedge clk);
            fs[c-16] <= 1'b0;
            repeat (6) @(posedge clk);
            #1;
            e = ~o0;
            chk("halved signal", 8'(e), 8'(monitor_zero_out));
        end
        $display("test halved signals done");
        finish_test();
    end
endmodule

bind csrm_bank csrm_bank_assertions #(.ADDR_W(ADDR_W)) chk_u (.*);

// ---- test/csrm_loop_model.sv ----
// behavioural loop side: status levels and slow toggles of the fast loop lines
module csrm_loop_model
    import csrm_pkg::*;
(
    // levels and toggles commanded by the bench
    input  wire logic [CSRM_ST_W-1:0] st,
    input  wire logic [CSRM_FS_W-1:0] fs,
    // status lines, held as levels like the analog detectors do
    output logic                      cleanup_locked,
    output logic                      synth_locked,
    output logic                      reference_input_a_ok,
    output logic                      reference_input_b_ok,
    output logic                      test_ref_ok,
    output logic                      vcxo_ok,
    output logic                      synth_fb_ok,
    output logic                      synth_ref_ok,
    output logic                      cleanup_fb_ok,
    output logic                      holdover_active,
    output logic                      auto_sel_ref_b,
    output logic                      vco_cal_busy,
    // fast lines, stepped slowly enough for the synchroniser to see every edge
    output logic                      cleanup_fb_clk,
    output logic                      pfd_down,
    output logic                      cleanup_ref_clk,
    output logic                      pfd_up
);
    timeunit 1ns;
    timeprecision 1ps;
    assign {vco_cal_busy, auto_sel_ref_b, holdover_active, cleanup_fb_ok, synth_ref_ok,
            synth_fb_ok, vcxo_ok, test_ref_ok, reference_input_b_ok, reference_input_a_ok,
            synth_locked, cleanup_locked} = st;
    assign {pfd_up, cleanup_ref_clk, pfd_down, cleanup_fb_clk} = fs;
endmodule
